// >>> common/pvp_pkg.sv
// Constants, register map and carrier types for the parallel video port.
// Assumes one system clock domain; pins arrive asynchronously.
package pvp_pkg;

  // Structure
  localparam int NUM_PORTS = 2;
  localparam int DATA_W    = 16;
  localparam int NUM_FS    = 3;
  localparam int ADDR_W    = 4;
  localparam int REG_W     = 16;
  localparam int IDX_W     = 3;

  // Register indices inside one port; address bit 3 selects the port
  localparam logic [IDX_W-1:0] REG_CONTROL  = 3'h0;
  localparam logic [IDX_W-1:0] REG_DELAY    = 3'h1;
  localparam logic [IDX_W-1:0] REG_COUNT    = 3'h2;
  localparam logic [IDX_W-1:0] REG_LINES    = 3'h3;
  localparam logic [IDX_W-1:0] REG_STATUS   = 3'h4;
  localparam int               PORT_SEL_BIT = 3;

  // Control fields
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_MODE_LSB   = 1;
  localparam int MODE_W         = 3;
  localparam int CTL_WIDTH_LSB  = 4;
  localparam int WIDTH_W        = 4;
  localparam int CTL_FSEN_LSB   = 8;

  // Submodes
  localparam logic [MODE_W-1:0] MODE_GP_IN   = 3'h0;
  localparam logic [MODE_W-1:0] MODE_CAPTURE = 3'h1;
  localparam logic [MODE_W-1:0] MODE_GP_OUT  = 3'h2;
  localparam logic [MODE_W-1:0] MODE_ITU_ACT = 3'h3;
  localparam logic [MODE_W-1:0] MODE_ITU_VBI = 3'h4;
  localparam logic [MODE_W-1:0] MODE_ITU_ALL = 3'h5;

  // Width code is bit count minus one
  localparam logic [WIDTH_W-1:0] WCODE_8  = 4'h7;
  localparam logic [WIDTH_W-1:0] WCODE_10 = 4'h9;
  localparam logic [WIDTH_W-1:0] WCODE_16 = 4'hf;
  localparam logic [DATA_W-1:0]  MASK_ALL = 16'hffff;

  // Timing reference word fields
  localparam logic [7:0] PRE_ONES  = 8'hff;
  localparam logic [7:0] PRE_ZEROS = 8'h00;
  localparam int XY_F_BIT = 6;
  localparam int XY_V_BIT = 5;
  localparam int XY_H_BIT = 4;
  localparam logic [1:0] PRE_IDLE = 2'h0;
  localparam logic [1:0] PRE_ONE  = 2'h1;
  localparam logic [1:0] PRE_TWO  = 2'h2;
  localparam logic [1:0] PRE_XY   = 2'h3;

  // Status bits
  localparam int ST_BUSY   = 0;
  localparam int ST_SYNCED = 1;
  localparam int ST_FIELD  = 2;
  localparam int ST_VBLANK = 3;
  localparam int ST_DONE   = 4;

  // Reset values
  localparam logic [REG_W-1:0] CTL_RESET   = 16'h0000;
  localparam logic [REG_W-1:0] DELAY_RESET = 16'h0000;
  localparam logic [REG_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [REG_W-1:0] LINES_RESET = 16'h0000;

  // Frame sync enables used by frame capture: first and second
  localparam logic [NUM_FS-1:0] FS_CAPTURE_OE = 3'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_XFER} pvp_state_type;

  typedef struct packed {
    logic              port_clock_in;
    logic [NUM_FS-1:0] frame_sync;
    logic [DATA_W-1:0] data;
  } pvp_pins_in_type;

  typedef struct packed {
    logic [NUM_FS-1:0] frame_sync;
    logic [NUM_FS-1:0] frame_sync_oe;
    logic [DATA_W-1:0] data;
    logic              data_oe;
  } pvp_pins_out_type;

endpackage

// >>> rtl/pvp_parallel_video_port.sv
// Two parallel video ports with register port and sample stream side.
// Assumes port clocks at most half core_clk_i; pins are asynchronous.
`timescale 1ns/1ps

module pvp_parallel_video_port (
  input  wire logic                                               core_clk_i,
  input  wire logic                                               reset_n_i,
  input  wire logic [pvp_pkg::ADDR_W-1:0]                         reg_addr_i,
  input  wire logic [pvp_pkg::REG_W-1:0]                          reg_wdata_i,
  input  wire logic                                               reg_wr_i,
  input  wire logic                                               reg_rd_i,
  output logic      [pvp_pkg::REG_W-1:0]                          reg_rdata_o,
  input  wire pvp_pkg::pvp_pins_in_type  [pvp_pkg::NUM_PORTS-1:0] pins_i,
  output pvp_pkg::pvp_pins_out_type      [pvp_pkg::NUM_PORTS-1:0] pins_o,
  output logic [pvp_pkg::NUM_PORTS-1:0][pvp_pkg::DATA_W-1:0]     rx_data_o,
  output logic [pvp_pkg::NUM_PORTS-1:0]                           rx_valid_o,
  input  wire logic [pvp_pkg::NUM_PORTS-1:0][pvp_pkg::DATA_W-1:0] tx_data_i,
  output logic [pvp_pkg::NUM_PORTS-1:0]                           tx_ready_o
);

  logic [pvp_pkg::REG_W-1:0]  port_rd_w [pvp_pkg::NUM_PORTS];
  logic [pvp_pkg::REG_W-1:0]  rdata_ff;
  logic [pvp_pkg::IDX_W-1:0]  reg_idx;
  logic                       reg_port;

  // Shared address decode
  assign reg_idx  = reg_addr_i[pvp_pkg::IDX_W-1:0];
  assign reg_port = reg_addr_i[pvp_pkg::PORT_SEL_BIT];

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= reg_rd_i ? port_rd_w[reg_port] : '0;
    end
  end
  assign reg_rdata_o = rdata_ff;

  for (genvar p = 0; p < pvp_pkg::NUM_PORTS; p++) begin : g_port
    logic [pvp_pkg::REG_W-1:0]   ctl_ff, dly_ff, cnt_ff, lines_ff;
    logic                        clk_s1_ff, clk_s2_ff, clk_prev_ff;
    logic [pvp_pkg::NUM_FS-1:0]  fs_s1_ff, fs_s2_ff;
    logic [pvp_pkg::DATA_W-1:0]  din_s1_ff, din_s2_ff;
    logic                        fs1_last_ff;
    pvp_pkg::pvp_state_type      state_ff, nxt_state;
    logic [pvp_pkg::REG_W-1:0]   dly_cnt_ff, smp_cnt_ff, line_cnt_ff;
    logic [1:0]                  pre_ff, nxt_pre;
    logic                        synced_ff, field_ff, vblank_ff, hblank_ff, done_ff;
    logic [pvp_pkg::NUM_FS-1:0]  fs_out_ff;
    logic [pvp_pkg::DATA_W-1:0]  dout_ff, rx_data_ff;
    logic                        rx_valid_ff;
    logic                        wr_sel, edge_w, en, fs1_rise, trigger, start_ok;
    logic                        last_smp, last_line, gp_read, itu_mode, itu_emit;
    logic                        is_ones, is_zeros, xy_hit, f1_start, sav_hit;
    logic                        m_in, m_cap, m_out, m_act, m_vbi, m_all;
    logic [pvp_pkg::MODE_W-1:0]  mode;
    logic [pvp_pkg::WIDTH_W-1:0] wcode, eff_code;
    logic [pvp_pkg::DATA_W-1:0]  mask, sample;
    logic [7:0]                  top8;
    logic [pvp_pkg::NUM_FS-1:0]  fs_en, fs_oe;

    // Register writes for this port
    assign wr_sel = reg_wr_i & (reg_port == 1'(p));
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        ctl_ff   <= pvp_pkg::CTL_RESET;
        dly_ff   <= pvp_pkg::DELAY_RESET;
        cnt_ff   <= pvp_pkg::COUNT_RESET;
        lines_ff <= pvp_pkg::LINES_RESET;
      end else if (wr_sel) begin
        if (reg_idx == pvp_pkg::REG_CONTROL) ctl_ff <= reg_wdata_i;
        if (reg_idx == pvp_pkg::REG_DELAY) dly_ff <= reg_wdata_i;
        if (reg_idx == pvp_pkg::REG_COUNT) cnt_ff <= reg_wdata_i;
        if (reg_idx == pvp_pkg::REG_LINES) lines_ff <= reg_wdata_i;
      end
    end

    // Register read selection, unmapped reads zero
    assign port_rd_w[p] =
      (reg_idx == pvp_pkg::REG_CONTROL) ? ctl_ff :
      (reg_idx == pvp_pkg::REG_DELAY)   ? dly_ff :
      (reg_idx == pvp_pkg::REG_COUNT)   ? cnt_ff :
      (reg_idx == pvp_pkg::REG_LINES)   ? lines_ff :
      (reg_idx == pvp_pkg::REG_STATUS)  ?
        {11'h000, done_ff, vblank_ff, field_ff, synced_ff, state_ff != pvp_pkg::ST_IDLE} :
      '0;

    // Two-stage synchronisers for port clock, syncs and data
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        clk_s1_ff   <= 1'b0;
        clk_s2_ff   <= 1'b0;
        clk_prev_ff <= 1'b0;
        fs_s1_ff    <= '0;
        fs_s2_ff    <= '0;
        din_s1_ff   <= '0;
        din_s2_ff   <= '0;
      end else begin
        clk_s1_ff   <= pins_i[p].port_clock_in;
        clk_s2_ff   <= clk_s1_ff;
        clk_prev_ff <= clk_s2_ff;
        fs_s1_ff    <= pins_i[p].frame_sync;
        fs_s2_ff    <= fs_s1_ff;
        din_s1_ff   <= pins_i[p].data;
        din_s2_ff   <= din_s1_ff;
      end
    end

    // Rising port clock edge is the single working edge
    assign edge_w = clk_s2_ff & ~clk_prev_ff;

    // Control decode
    assign en    = ctl_ff[pvp_pkg::CTL_ENABLE_BIT];
    assign mode  = ctl_ff[pvp_pkg::CTL_MODE_LSB +: pvp_pkg::MODE_W];
    assign wcode = ctl_ff[pvp_pkg::CTL_WIDTH_LSB +: pvp_pkg::WIDTH_W];
    assign fs_en = ctl_ff[pvp_pkg::CTL_FSEN_LSB +: pvp_pkg::NUM_FS];
    assign m_in  = en & (mode == pvp_pkg::MODE_GP_IN);
    assign m_cap = en & (mode == pvp_pkg::MODE_CAPTURE);
    assign m_out = en & (mode == pvp_pkg::MODE_GP_OUT);
    assign m_act = en & (mode == pvp_pkg::MODE_ITU_ACT);
    assign m_vbi = en & (mode == pvp_pkg::MODE_ITU_VBI);
    assign m_all = en & (mode == pvp_pkg::MODE_ITU_ALL);
    assign itu_mode = m_act | m_vbi | m_all;

    // Width: 8 or 10..16 bits; video modes force 8 or 10
    assign eff_code = itu_mode ? ((wcode == pvp_pkg::WCODE_10) ? pvp_pkg::WCODE_10
                                                               : pvp_pkg::WCODE_8)
                    : ((wcode == pvp_pkg::WCODE_8 || wcode >= pvp_pkg::WCODE_10)
                       ? wcode : pvp_pkg::WCODE_16);
    assign mask   = pvp_pkg::MASK_ALL >> (pvp_pkg::WCODE_16 - eff_code);
    assign sample = din_s2_ff & mask;

    // Timing code recognition on the upper eight bits of a sample
    assign top8     = (eff_code == pvp_pkg::WCODE_10) ? sample[9:2] : sample[7:0];
    assign is_ones  = (top8 == pvp_pkg::PRE_ONES);
    assign is_zeros = (top8 == pvp_pkg::PRE_ZEROS);
    assign xy_hit   = edge_w & itu_mode & (pre_ff == pvp_pkg::PRE_XY);
    assign f1_start = xy_hit & ~top8[pvp_pkg::XY_F_BIT] & field_ff;
    assign sav_hit  = xy_hit & ~top8[pvp_pkg::XY_H_BIT] & ~top8[pvp_pkg::XY_V_BIT];

    // Preamble stage: ones, zeros, zeros, then the timing word
    always_comb begin
      nxt_pre = is_ones ? pvp_pkg::PRE_ONE : pvp_pkg::PRE_IDLE;
      case (pre_ff)
        pvp_pkg::PRE_ONE: if (is_zeros) nxt_pre = pvp_pkg::PRE_TWO;
        pvp_pkg::PRE_TWO: if (is_zeros) nxt_pre = pvp_pkg::PRE_XY;
        pvp_pkg::PRE_XY:  nxt_pre = pvp_pkg::PRE_IDLE;
        default:          nxt_pre = nxt_pre;
      endcase
    end

    // Which video samples go out
    assign itu_emit = synced_ff & ((m_all)
      | (m_act & ~done_ff & ~hblank_ff & ~vblank_ff & ~is_ones
         & (pre_ff == pvp_pkg::PRE_IDLE))
      | (m_vbi & vblank_ff & ~is_ones & (pre_ff == pvp_pkg::PRE_IDLE)));

    // Video timing state
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        pre_ff    <= pvp_pkg::PRE_IDLE;
        synced_ff <= 1'b0;
        field_ff  <= 1'b0;
        vblank_ff <= 1'b1;
        hblank_ff <= 1'b1;
      end else if (!itu_mode) begin
        pre_ff    <= pvp_pkg::PRE_IDLE;
        synced_ff <= 1'b0;
      end else if (edge_w) begin
        pre_ff <= nxt_pre;
        if (xy_hit) begin
          field_ff  <= top8[pvp_pkg::XY_F_BIT];
          vblank_ff <= top8[pvp_pkg::XY_V_BIT];
          hblank_ff <= top8[pvp_pkg::XY_H_BIT];
        end
        if (f1_start) synced_ff <= 1'b1;
      end
    end

    // General-purpose sequencing
    assign fs1_rise  = edge_w & fs_s2_ff[0] & ~fs1_last_ff;
    assign start_ok  = (cnt_ff != '0) & (state_ff == pvp_pkg::ST_IDLE);
    assign trigger   = start_ok & ((m_in & fs1_rise) | (edge_w & (m_cap | m_out)));
    assign last_smp  = (smp_cnt_ff == cnt_ff - 16'h0001);
    assign last_line = (line_cnt_ff >= lines_ff - 16'h0001);
    assign gp_read   = edge_w & (state_ff == pvp_pkg::ST_XFER) & (m_in | m_cap);

    // Next state of the sequencer
    always_comb begin
      nxt_state = state_ff;
      case (state_ff)
        pvp_pkg::ST_IDLE:
          if (trigger) nxt_state = (dly_ff == '0) ? pvp_pkg::ST_XFER : pvp_pkg::ST_DELAY;
        pvp_pkg::ST_DELAY:
          if (edge_w && dly_cnt_ff == dly_ff) nxt_state = pvp_pkg::ST_XFER;
        pvp_pkg::ST_XFER:
          if (edge_w && last_smp) nxt_state = pvp_pkg::ST_IDLE;
        default: nxt_state = pvp_pkg::ST_IDLE;
      endcase
      if (!(m_in | m_cap | m_out)) nxt_state = pvp_pkg::ST_IDLE;
    end

    // Sequencer registers and counters
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        state_ff    <= pvp_pkg::ST_IDLE;
        fs1_last_ff <= 1'b0;
        dly_cnt_ff  <= '0;
        smp_cnt_ff  <= '0;
        line_cnt_ff <= '0;
        done_ff     <= 1'b0;
      end else begin
        state_ff <= nxt_state;
        if (edge_w) fs1_last_ff <= fs_s2_ff[0];
        if (trigger) dly_cnt_ff <= 16'h0001;
        else if (edge_w) dly_cnt_ff <= dly_cnt_ff + 16'h0001;
        if (state_ff != pvp_pkg::ST_XFER) smp_cnt_ff <= '0;
        else if (edge_w) smp_cnt_ff <= smp_cnt_ff + 16'h0001;
        if (!en) begin
          line_cnt_ff <= '0;
          done_ff     <= 1'b0;
        end else if (itu_mode) begin
          if (f1_start) begin
            line_cnt_ff <= '0;
            done_ff     <= 1'b0;
          end else if (sav_hit && synced_ff) begin
            if (line_cnt_ff == cnt_ff) done_ff <= 1'b1;
            else line_cnt_ff <= line_cnt_ff + 16'h0001;
          end
        end else if (m_cap && edge_w && state_ff == pvp_pkg::ST_XFER && last_smp) begin
          line_cnt_ff <= last_line ? '0 : line_cnt_ff + 16'h0001;
        end
      end
    end

    // Frame sync direction per submode
    assign fs_oe = m_cap ? pvp_pkg::FS_CAPTURE_OE : (m_out ? fs_en : '0);

    // Sync outputs, output data and captured samples change on the working edge
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        fs_out_ff   <= '0;
        dout_ff     <= '0;
        rx_data_ff  <= '0;
        rx_valid_ff <= 1'b0;
      end else begin
        if (edge_w) begin
          fs_out_ff <= '0;
          if (trigger && m_cap) begin
            fs_out_ff <= {1'b0, line_cnt_ff == '0, 1'b1};
          end else if (trigger && m_out) begin
            fs_out_ff <= fs_en;
          end
        end
        if (edge_w && m_out && state_ff == pvp_pkg::ST_XFER) begin
          dout_ff <= tx_data_i[p] & mask;
        end
        rx_valid_ff <= gp_read | (edge_w & itu_emit);
        if (gp_read || (edge_w && itu_emit)) rx_data_ff <= sample;
      end
    end

    // Pin and stream outputs
    assign pins_o[p].frame_sync    = fs_out_ff;
    assign pins_o[p].frame_sync_oe = fs_oe;
    assign pins_o[p].data          = dout_ff;
    assign pins_o[p].data_oe       = m_out;
    assign rx_data_o[p]            = rx_data_ff;
    assign rx_valid_o[p]           = rx_valid_ff;
    assign tx_ready_o[p] = edge_w & m_out & (state_ff == pvp_pkg::ST_XFER);
  end

endmodule

// >>> sim/pvp_parallel_video_port_tb_top.sv
// Self-checking bench: port 0 receives and captures, port 1 sends meanwhile.
// Assumes the checker is bound to the design and partners sit on both ports.
`timescale 1ns/1ps
module pvp_parallel_video_port_tb_top;
  logic                   core_clk = 1'b0;
  logic                   reset_n  = 1'b0;
  logic [3:0]             reg_addr = '0;
  logic [15:0]            reg_wdata = '0;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic [15:0]            reg_rdata;
  pvp_pkg::pvp_pins_in_type  [1:0] pins_in;
  pvp_pkg::pvp_pins_out_type [1:0] pins_out;
  logic [1:0][15:0]       rx_data;
  logic [1:0]             rx_valid;
  logic [1:0][15:0]       tx_data = '0;
  logic [1:0]             tx_ready;
  logic [1:0]             run = '0;
  logic [1:0][2:0]        fs_req = '0;
  logic [1:0][15:0]       word = '0;
  logic [1:0]             pclk;
  logic [1:0][15:0]       got;
  logic [1:0][2:0]        got_fs;
  logic [1:0][2:0]        seen_fs = '0;
  logic [15:0]            exp_rd[$];
  logic [15:0]            exp_rx[$];
  logic [15:0]            exp_tx[$];
  logic                   rd_d = 1'b0;
  logic                   cap_mode = 1'b0;
  logic [15:0]            cap_word = '0;
  int                     n_errors = 0;
  int                     samples_checked = 0;
  int                     n_tx = 0;
  int                     n_cap = 0;
  int                     seed = 32'h84245b03;

  always #12.5 core_clk = ~core_clk;

  pvp_parallel_video_port i_pvp_parallel_video_port (
    .core_clk_i(core_clk), .reset_n_i(reset_n), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .pins_i(pins_in), .pins_o(pins_out), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .tx_data_i(tx_data), .tx_ready_o(tx_ready));

  for (genvar p = 0; p < 2; p++) begin : g_far
    pvp_partner #(.HALF(100.0), .START(5.0 + p * 41.0)) i_pvp_partner (
      .run_i(run[p]), .fs_i(fs_req[p]), .word_i(word[p]), .port_i(pins_out[p]),
      .pins_o(pins_in[p]), .pclk_o(pclk[p]), .got_o(got[p]), .got_fs_o(got_fs[p]));
  end

  task automatic cmp_data(input logic [15:0] g, input logic [15:0] e, input string what);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t ns: %s got %h want %h", $time, what, g, e);
    end
  endtask

  task automatic cmp_sync(input logic [2:0] g, input logic [2:0] e, input string what);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t ns: %s got %b want %b", $time, what, g, e);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_rd.push_back(e);
    @(posedge core_clk);
    reg_rd   <= 1'b0;
  endtask

  // One input frame on port 0 with a second sync rise while busy when d + cnt > 2
  task automatic gp_frame(input logic [3:0] code, input int d, input int cnt);
    logic [15:0] mask;
    logic [15:0] w;
    mask = 16'hffff >> (4'hf - code);
    reg_write(4'h1, 16'(d));
    reg_write(4'h2, 16'(cnt));
    reg_write(4'h0, {8'h00, code, pvp_pkg::MODE_GP_IN, 1'b1});
    for (int j = 0; j < d + cnt + 4; j++) begin
      @(posedge pclk[0]);
      @(posedge core_clk);
      w = 16'($random(seed));
      word[0]   <= w;
      fs_req[0] <= {2'b00, j == 0 || (j == 2 && d + cnt > 2)};
      if (j > d && j <= d + cnt) exp_rx.push_back(w & mask);
    end
    reg_write(4'h0, 16'h0000);
    cmp_data(16'(exp_rx.size()), 16'h0000, "samples missing");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Register read checker
  always @(posedge core_clk) rd_d <= reg_rd;
  always @(negedge core_clk) if (rd_d) cmp_data(reg_rdata, exp_rd.pop_front(), "read");

  // Received samples on port 0
  always @(negedge core_clk) begin
    if (rx_valid[0] === 1'b1) begin
      if (cap_mode) begin
        n_cap++;
        cmp_data(rx_data[0], cap_word & 16'h00ff, "captured sample");
      end else if (exp_rx.size() == 0) begin
        n_errors++;
        $display("unexpected at %0t ns: extra sample %h", $time, rx_data[0]);
      end else cmp_data(rx_data[0], exp_rx.pop_front(), "sample");
    end
  end

  // Port 1 send side: new random word each cycle, note what the port takes
  always @(posedge core_clk) tx_data[1] <= 16'($random(seed));
  always @(negedge core_clk) begin
    if (tx_ready[1] === 1'b1) begin
      exp_tx.push_back(tx_data[1]);
      n_tx++;
    end
  end

  // What each far side saw at its clock rise
  always @(posedge pclk[0]) #1 seen_fs[0] = seen_fs[0] | got_fs[0];
  always @(posedge pclk[1]) begin
    #1;
    seen_fs[1] = seen_fs[1] | got_fs[1];
    if (exp_tx.size() > 0) cmp_data(got[1], exp_tx.pop_front(), "driven sample");
  end

  // Main sequence
  initial begin
    logic [15:0] w;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (i % 8 < 4) reg_read(4'(i), 16'h0000);
    end
    reg_read(4'h4, 16'h0008);
    reg_write(4'hc, 16'hffff);
    reg_read(4'hc, 16'h0008);
    reg_read(4'h5, 16'h0000);
    for (int i = 1; i < 4; i++) begin
      w = 16'($random(seed));
      reg_write(4'(8 + i), w);
      reg_read(4'(8 + i), w);
    end
    reg_write(4'h9, 16'h0001);
    reg_write(4'ha, 16'h0002);
    reg_write(4'h8, {5'h00, 3'h5, pvp_pkg::WCODE_16, pvp_pkg::MODE_GP_OUT, 1'b1});
    run <= 2'b11;
    for (int c = 7; c < 16; c++) begin
      if (c != 8) gp_frame(4'(c), c % 3, 1 + c % 4);
    end
    cap_word = 16'($random(seed));
    word[0] <= cap_word;
    reg_write(4'h3, 16'h0002);
    reg_write(4'h1, 16'h0000);
    reg_write(4'h2, 16'h0002);
    seen_fs[0] = '0;
    cap_mode = 1'b1;
    reg_write(4'h0, {8'h00, pvp_pkg::WCODE_8, pvp_pkg::MODE_CAPTURE, 1'b1});
    repeat (12) @(posedge pclk[0]);
    reg_write(4'h0, 16'h0000);
    repeat (2) @(posedge pclk[0]);
    cap_mode = 1'b0;
    cmp_sync(seen_fs[0], 3'h3, "capture syncs");
    cmp_data(16'(n_cap != 0), 16'h0001, "captures");
    run <= 2'b00;
    repeat (20) @(posedge core_clk);
    cmp_sync(seen_fs[1], 3'h5, "output syncs");
    cmp_data(16'(n_tx != 0), 16'h0001, "sends");
    tally_and_finish;
  end

  // Watchdog against a hang
  initial begin
    #1_000_000;
    n_errors++;
    tally_and_finish;
  end
endmodule

// >>> sim/pvp_partner.sv
// Far side of one port: converter or video source/sink with its own port clock.
// Assumes the bench supplies sync levels and words; pins resolve by output enables.
`timescale 1ns/1ps
module pvp_partner #(
  parameter realtime HALF  = 100.0,
  parameter realtime START = 5.0
) (
  input  wire logic                       run_i,
  input  wire logic [pvp_pkg::NUM_FS-1:0] fs_i,
  input  wire logic [pvp_pkg::DATA_W-1:0] word_i,
  input  wire pvp_pkg::pvp_pins_out_type  port_i,
  output pvp_pkg::pvp_pins_in_type        pins_o,
  output logic                            pclk_o,
  output logic [pvp_pkg::DATA_W-1:0]      got_o,
  output logic [pvp_pkg::NUM_FS-1:0]      got_fs_o
);
  logic [pvp_pkg::NUM_FS-1:0] fs_q   = '0;
  logic [pvp_pkg::DATA_W-1:0] word_q = '0;

  // Port clock at half the system rate or slower, parked low when not running
  initial begin
    pclk_o = 1'b0;
    #START;
    forever begin
      #HALF;
      if (run_i || pclk_o) pclk_o = ~pclk_o;
    end
  end

  // Source changes after the falling edge so the port sees settled levels at the rise
  always @(negedge pclk_o) begin
    fs_q   <= fs_i;
    word_q <= word_i;
  end

  // Wire levels: the port owns every line it enables, the far side yields
  assign pins_o.port_clock_in = pclk_o;
  assign pins_o.frame_sync    = (port_i.frame_sync_oe & port_i.frame_sync)
                              | (~port_i.frame_sync_oe & fs_q);
  assign pins_o.data          = port_i.data_oe ? port_i.data : word_q;

  // Sink samples the wire on the rising edge
  always @(posedge pclk_o) begin
    got_o    <= pins_o.data;
    got_fs_o <= pins_o.frame_sync;
  end
endmodule

// >>> sim/pvp_properties.sv
// Concurrent checks on the ports of the parallel video port.
// Assumes one core clock domain; the bench changes control while idle except when it stops capture mid-transfer.
`timescale 1ns/1ps
module pvp_properties (
  input wire logic                                                core_clk_i,
  input wire logic                                                reset_n_i,
  input wire logic [pvp_pkg::ADDR_W-1:0]                          reg_addr_i,
  input wire logic [pvp_pkg::REG_W-1:0]                           reg_wdata_i,
  input wire logic                                                reg_wr_i,
  input wire logic                                                reg_rd_i,
  input wire logic [pvp_pkg::REG_W-1:0]                           reg_rdata_o,
  input wire pvp_pkg::pvp_pins_in_type  [pvp_pkg::NUM_PORTS-1:0]  pins_i,
  input wire pvp_pkg::pvp_pins_out_type [pvp_pkg::NUM_PORTS-1:0]  pins_o,
  input wire logic [pvp_pkg::NUM_PORTS-1:0][pvp_pkg::DATA_W-1:0]  rx_data_o,
  input wire logic [pvp_pkg::NUM_PORTS-1:0]                       rx_valid_o,
  input wire logic [pvp_pkg::NUM_PORTS-1:0][pvp_pkg::DATA_W-1:0]  tx_data_i,
  input wire logic [pvp_pkg::NUM_PORTS-1:0]                       tx_ready_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  // Read data only in the cycle after a read strobe
  a_rdata_quiet : assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data outside its cycle");

  for (genvar p = 0; p < pvp_pkg::NUM_PORTS; p++) begin : g_port
    logic [pvp_pkg::REG_W-1:0] ctl_ff;
    logic                      pclk_ff;
    logic [3:0]                age_ff;
    // Shadow of control and age of the last port clock rise
    wire logic       ctl_hit = reg_wr_i && reg_addr_i[pvp_pkg::PORT_SEL_BIT] == 1'(p)
                               && reg_addr_i[2:0] == pvp_pkg::REG_CONTROL;
    wire logic       en      = ctl_ff[pvp_pkg::CTL_ENABLE_BIT];
    wire logic [2:0] mode    = ctl_ff[pvp_pkg::CTL_MODE_LSB +: pvp_pkg::MODE_W];
    wire logic [3:0] nxt_age = (pins_i[p].port_clock_in && !pclk_ff) ? 4'h0 :
                               (age_ff == 4'hf) ? age_ff : age_ff + 4'h1;
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        ctl_ff  <= '0;
        pclk_ff <= 1'b0;
        age_ff  <= 4'hf;
      end else begin
        if (ctl_hit) ctl_ff <= reg_wdata_i;
        pclk_ff <= pins_i[p].port_clock_in;
        age_ff  <= nxt_age;
      end
    end
    a_rx_single : assert property (rx_valid_o[p] |=> !rx_valid_o[p])
      else $error("sample strobe longer than one cycle");
    a_tx_single : assert property (tx_ready_o[p] |=> !tx_ready_o[p])
      else $error("send strobe longer than one cycle");
    a_link_edge : assert property ((rx_valid_o[p] || tx_ready_o[p]) |-> age_ff <= 4'h6)
      else $error("transfer without a recent port clock rise");
    a_in_no_drive : assert property (en && mode == pvp_pkg::MODE_GP_IN |->
      pins_o[p].frame_sync_oe == '0 && !pins_o[p].data_oe)
      else $error("input submode drives a pin");
    a_cap_drive : assert property (en && mode == pvp_pkg::MODE_CAPTURE |->
      pins_o[p].frame_sync_oe == pvp_pkg::FS_CAPTURE_OE && !pins_o[p].data_oe)
      else $error("capture submode pin directions wrong");
    a_out_drive : assert property (en && mode == pvp_pkg::MODE_GP_OUT |->
      pins_o[p].data_oe && pins_o[p].frame_sync_oe == ctl_ff[10:8])
      else $error("output submode pin directions wrong");
    a_half_duplex : assert property (rx_valid_o[p] |-> mode != pvp_pkg::MODE_GP_OUT)
      else $error("sample taken in output submode");
    a_tx_mode : assert property (tx_ready_o[p] |-> en && mode == pvp_pkg::MODE_GP_OUT)
      else $error("send strobe outside output submode");
  end

  // Main scenarios reached
  c_rx_sample : cover property (rx_valid_o[0]);
  c_tx_sample : cover property (tx_ready_o[1]);
  c_vsync     : cover property (pins_o[0].frame_sync[1] && pins_o[0].frame_sync_oe[1]);
endmodule

bind pvp_parallel_video_port pvp_properties i_pvp_properties (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .pins_i(pins_i), .pins_o(pins_o), .rx_data_o(rx_data_o),
  .rx_valid_o(rx_valid_o), .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o));
